/* cop_port.sv */
// Debug observation port: test access logic and reset line handling
`timescale 1ns/10ps
`default_nettype none
module cop_port
  import cop_port_pkg::*;
#(
  parameter int DATA_W = cop_port_pkg::DATA_WIDTH,
  parameter int DEPTH = cop_port_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Test port from the header
  input wire logic tck,
  input wire logic trst_n,
  input wire logic trst_driven,
  input wire logic tms,
  input wire logic tms_driven,
  input wire logic tdi,
  input wire logic tdi_driven,
  output logic tdo,
  output logic tdo_oe,
  // Quiesce request
  output logic quiesce_request_n,
  // Open-drain soft reset line
  input wire logic soft_reset_n_in,
  output logic soft_reset_n_out,
  output logic soft_reset_n_oe,
  // Open-drain hard reset line
  input wire logic hard_reset_n_in,
  output logic hard_reset_n_out,
  output logic hard_reset_n_oe,
  // Multiplexed header pin
  input wire logic checkstop_sel,
  input wire logic alt_pin_function_out,
  input wire logic alt_pin_function_oe,
  output logic alt_pin_in,
  output logic alt_pin_out,
  output logic alt_pin_oe,
  input wire logic alt_pin_pad,
  // Core side
  input wire logic core_quiesce,
  input wire logic core_checkstop,
  input wire logic core_soft_req,
  input wire logic core_hard_req,
  output logic core_soft_exception,
  output logic core_hard_reset,
  // Debug words received from the station
  output logic [DATA_W-1:0] debug_data,
  output logic debug_valid,
  input wire logic debug_ready
);
  import cop_port_pkg::*;

  initial begin
    if (DATA_W < STATUS_WIDTH) begin
      $error("cop_port: DATA_W must be at least the status width");
    end
  end

  function automatic tap_state_t tap_next(input tap_state_t s,
                                          input logic m);
    unique case (s)
      TEST_LOGIC_RESET: tap_next = m ? TEST_LOGIC_RESET : RUN_IDLE;
      RUN_IDLE: tap_next = m ? SELECT_DR : RUN_IDLE;
      SELECT_DR: tap_next = m ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: tap_next = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: tap_next = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: tap_next = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: tap_next = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: tap_next = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: tap_next = m ? SELECT_DR : RUN_IDLE;
      SELECT_IR: tap_next = m ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: tap_next = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: tap_next = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: tap_next = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: tap_next = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: tap_next = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: tap_next = m ? SELECT_DR : RUN_IDLE;
    endcase
  endfunction

  // Test clock domain
  logic test_rst_n;
  logic tms_eff;
  logic tdi_eff;
  tap_state_t tap_q;
  logic [IR_WIDTH-1:0] ir_sr_q;
  logic [IR_WIDTH-1:0] ir_q;
  logic bypass_q;
  logic [DATA_W-1:0] data_sr_q;
  logic [STATUS_WIDTH-1:0] status_sr_q;
  logic [DATA_W-1:0] xfer_word_q;
  logic xfer_req_q;
  logic ack_t1_q;
  logic ack_t2_q;
  logic overflow_q;
  logic [STATUS_WIDTH-1:0] st_t1_q;
  logic [STATUS_WIDTH-1:0] st_t2_q;
  logic xfer_busy;
  logic serial_out;
  logic ack_q;
  logic [STATUS_WIDTH-1:0] status_clk_q;

  // Board pull-down keeps test logic reset with no station
  assign test_rst_n = trst_driven & trst_n;
  // Floating inputs rise to the internal pull-up level
  assign tms_eff = tms_driven ? tms : 1'b1;
  assign tdi_eff = tdi_driven ? tdi : 1'b1;
  assign xfer_busy = (xfer_req_q != ack_t2_q);

  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      tap_q <= TEST_LOGIC_RESET;
    end else begin
      tap_q <= tap_next(tap_q, tms_eff);
    end
  end

  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      ir_sr_q <= IR_RESET;
    end else if (tap_q == CAPTURE_IR) begin
      ir_sr_q <= IR_CAPTURE;
    end else if (tap_q == SHIFT_IR) begin
      ir_sr_q <= {tdi_eff, ir_sr_q[IR_WIDTH-1:1]};
    end
  end

  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      ir_q <= OP_BYPASS;
    end else if (tap_q == TEST_LOGIC_RESET) begin
      ir_q <= OP_BYPASS;
    end else if (tap_q == UPDATE_IR) begin
      ir_q <= ir_sr_q;
    end
  end

  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      bypass_q <= 1'b0;
    end else if (tap_q == CAPTURE_DR) begin
      bypass_q <= 1'b0;
    end else if (tap_q == SHIFT_DR) begin
      bypass_q <= tdi_eff;
    end
  end

  // Capture shows the last word handed over, for read-back
  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      data_sr_q <= '0;
    end else if (tap_q == CAPTURE_DR && ir_q == OP_DATA_WR) begin
      data_sr_q <= xfer_word_q;
    end else if (tap_q == SHIFT_DR && ir_q == OP_DATA_WR) begin
      data_sr_q <= {tdi_eff, data_sr_q[DATA_W-1:1]};
    end
  end

  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      status_sr_q <= '0;
    end else if (tap_q == CAPTURE_DR && ir_q == OP_STATUS_RD) begin
      status_sr_q <= {overflow_q, xfer_busy,
                      st_t2_q[STATUS_WIDTH-3:0]};
    end else if (tap_q == SHIFT_DR && ir_q == OP_STATUS_RD) begin
      status_sr_q <= {tdi_eff, status_sr_q[STATUS_WIDTH-1:1]};
    end
  end

  // A word can only be handed over once the last one is taken
  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      xfer_word_q <= '0;
      xfer_req_q <= 1'b0;
    end else if (tap_q == UPDATE_DR && ir_q == OP_DATA_WR &&
                 !xfer_busy) begin
      xfer_word_q <= data_sr_q;
      xfer_req_q <= !xfer_req_q;
    end
  end

  // Sticky until test reset; test reset wins over set
  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      overflow_q <= 1'b0;
    end else if (tap_q == UPDATE_DR && ir_q == OP_DATA_WR &&
                 xfer_busy) begin
      overflow_q <= 1'b1;
    end
  end

  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      ack_t1_q <= 1'b0;
      ack_t2_q <= 1'b0;
      st_t1_q <= '0;
      st_t2_q <= '0;
    end else begin
      ack_t1_q <= ack_q;
      ack_t2_q <= ack_t1_q;
      st_t1_q <= status_clk_q;
      st_t2_q <= st_t1_q;
    end
  end

  always_comb begin
    serial_out = 1'b0;
    if (tap_q == SHIFT_IR) begin
      serial_out = ir_sr_q[0];
    end else if (tap_q == SHIFT_DR) begin
      unique case (ir_q)
        OP_DATA_WR: serial_out = data_sr_q[0];
        OP_STATUS_RD: serial_out = status_sr_q[0];
        default: serial_out = bypass_q;
      endcase
    end
  end

  // Station samples on the rising edge, so launch half a period early
  always_ff @(negedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= serial_out;
      tdo_oe <= (tap_q == SHIFT_IR) || (tap_q == SHIFT_DR);
    end
  end

  // System clock domain
  logic req_s1_q;
  logic req_s2_q;
  logic [2:0] soft_sync_q;
  logic [2:0] hard_sync_q;
  logic soft_line_q;
  logic hard_line_q;
  logic soft_drive_q;
  logic hard_drive_q;
  logic [PULSE_CNT_WIDTH-1:0] soft_cnt_q;
  logic [PULSE_CNT_WIDTH-1:0] hard_cnt_q;
  logic soft_start;
  logic hard_start;
  logic exception_q;
  logic [2:0] alt_sync_q;
  logic alt_in_q;
  logic fifo_full;

  stream_if #(.WIDTH(DATA_W)) to_fifo ();
  stream_if #(.WIDTH(DATA_W)) from_fifo ();

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= xfer_req_q;
      req_s2_q <= req_s1_q;
    end
  end

  // Word is stable while the request is unanswered
  assign to_fifo.valid = (req_s2_q != ack_q);
  assign to_fifo.data = xfer_word_q;
  assign fifo_full = !to_fifo.ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (to_fifo.valid && to_fifo.ready) begin
      ack_q <= req_s2_q;
    end
  end

  word_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr(to_fifo),
    .rd(from_fifo)
  );

  assign debug_valid = from_fifo.valid;
  assign debug_data = from_fifo.data;
  assign from_fifo.ready = debug_ready;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_sync_q <= 3'h7;
      hard_sync_q <= 3'h7;
      alt_sync_q <= 3'h7;
    end else begin
      soft_sync_q <= {soft_sync_q[1:0], soft_reset_n_in};
      hard_sync_q <= {hard_sync_q[1:0], hard_reset_n_in};
      alt_sync_q <= {alt_sync_q[1:0], alt_pin_pad};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_line_q <= 1'b1;
      hard_line_q <= 1'b1;
      alt_in_q <= 1'b1;
    end else begin
      if (soft_sync_q[1] == soft_sync_q[2]) begin
        soft_line_q <= soft_sync_q[2];
      end
      if (hard_sync_q[1] == hard_sync_q[2]) begin
        hard_line_q <= hard_sync_q[2];
      end
      if (alt_sync_q[1] == alt_sync_q[2]) begin
        alt_in_q <= alt_sync_q[2];
      end
    end
  end

  // Our own low on the line must not retrigger the sequence
  assign soft_start = !soft_drive_q && !hard_drive_q &&
    (core_soft_req ||
     (soft_line_q && soft_sync_q[1] == soft_sync_q[2] &&
      !soft_sync_q[2]));
  assign hard_start = !hard_drive_q &&
    (core_hard_req ||
     (hard_line_q && hard_sync_q[1] == hard_sync_q[2] &&
      !hard_sync_q[2]));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_drive_q <= 1'b0;
      soft_cnt_q <= '0;
    end else if (hard_start) begin
      soft_drive_q <= 1'b0;
      soft_cnt_q <= '0;
    end else if (soft_start) begin
      soft_drive_q <= 1'b1;
      soft_cnt_q <= '0;
    end else if (soft_drive_q) begin
      soft_cnt_q <= soft_cnt_q + 1'b1;
      if (soft_cnt_q == PULSE_LAST) begin
        soft_drive_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hard_drive_q <= 1'b0;
      hard_cnt_q <= '0;
    end else if (hard_start) begin
      hard_drive_q <= 1'b1;
      hard_cnt_q <= '0;
    end else if (hard_drive_q) begin
      hard_cnt_q <= hard_cnt_q + 1'b1;
      if (hard_cnt_q == PULSE_LAST) begin
        hard_drive_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exception_q <= 1'b0;
    end else begin
      exception_q <= soft_start && !hard_start;
    end
  end

  // Lines only ever pulled low; pull-ups give the high level
  assign soft_reset_n_out = 1'b0;
  assign soft_reset_n_oe = soft_drive_q;
  assign hard_reset_n_out = 1'b0;
  assign hard_reset_n_oe = hard_drive_q;
  assign core_soft_exception = exception_q;
  assign core_hard_reset = hard_drive_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiesce_request_n <= 1'b1;
    end else begin
      quiesce_request_n <= !core_quiesce;
    end
  end

  // Default use leaves the pin to the unrelated function
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_pin_out <= 1'b1;
      alt_pin_oe <= 1'b0;
    end else if (checkstop_sel) begin
      alt_pin_out <= !core_checkstop;
      alt_pin_oe <= 1'b1;
    end else begin
      alt_pin_out <= alt_pin_function_out;
      alt_pin_oe <= alt_pin_function_oe;
    end
  end

  assign alt_pin_in = alt_in_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_clk_q <= '0;
    end else begin
      status_clk_q <= '0;
      status_clk_q[ST_ONE] <= 1'b1;
      status_clk_q[ST_SOFT_SEQ] <= soft_drive_q;
      status_clk_q[ST_HARD_SEQ] <= hard_drive_q;
      status_clk_q[ST_QUIESCE] <= core_quiesce;
      status_clk_q[ST_CHECKSTOP] <= core_checkstop;
      status_clk_q[ST_FIFO_FULL] <= fifo_full;
    end
  end
endmodule
`default_nettype wire

/* cop_port_bench.sv */
// Self-checking bench for the debug observation port
`timescale 1ns/10ps
`default_nettype none
module cop_port_bench;
  import cop_port_pkg::*;
  logic clk, rst_n, core_quiesce, core_checkstop, core_soft_req;
  logic core_hard_req, checkstop_sel, alt_pin_function_out;
  logic alt_pin_function_oe, alt_pin_pad, debug_ready;
  logic tck, trst_n, trst_driven, tms, tms_driven, tdi, tdi_driven;
  logic soft_pull, hard_pull, tdo, tdo_oe, quiesce_request_n;
  logic soft_reset_n_out, soft_reset_n_oe, hard_reset_n_out;
  logic hard_reset_n_oe, alt_pin_in, alt_pin_out, alt_pin_oe;
  logic core_soft_exception, core_hard_reset, debug_valid;
  logic [31:0] debug_data;
  wire soft_reset_n_in;
  wire hard_reset_n_in;
  int fails = 0;
  int n_checks = 0;

  // Pulled-up open-drain lines
  assign soft_reset_n_in = !((soft_reset_n_oe && !soft_reset_n_out) ||
                             soft_pull);
  assign hard_reset_n_in = !((hard_reset_n_oe && !hard_reset_n_out) ||
                             hard_pull);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  debug_station st (.tck(tck), .trst_n(trst_n), .trst_driven(trst_driven),
    .tms(tms), .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven),
    .tdo(tdo), .soft_pull(soft_pull), .hard_pull(hard_pull));

  cop_port cop_port_inst (.clk(clk), .rst_n(rst_n), .tck(tck),
    .trst_n(trst_n), .trst_driven(trst_driven), .tms(tms),
    .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven),
    .tdo(tdo), .tdo_oe(tdo_oe), .quiesce_request_n(quiesce_request_n),
    .soft_reset_n_in(soft_reset_n_in), .soft_reset_n_out(soft_reset_n_out),
    .soft_reset_n_oe(soft_reset_n_oe), .hard_reset_n_in(hard_reset_n_in),
    .hard_reset_n_out(hard_reset_n_out), .hard_reset_n_oe(hard_reset_n_oe),
    .checkstop_sel(checkstop_sel), .alt_pin_function_out(alt_pin_function_out),
    .alt_pin_function_oe(alt_pin_function_oe), .alt_pin_in(alt_pin_in),
    .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe),
    .alt_pin_pad(alt_pin_pad), .core_quiesce(core_quiesce),
    .core_checkstop(core_checkstop), .core_soft_req(core_soft_req),
    .core_hard_req(core_hard_req), .core_soft_exception(core_soft_exception),
    .core_hard_reset(core_hard_reset), .debug_data(debug_data),
    .debug_valid(debug_valid), .debug_ready(debug_ready));

  task automatic print_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd_status(output logic [31:0] s);
    logic [31:0] d;
    st.scan(1'h1, {28'h000_0000, OP_STATUS_RD}, 4, d);
    st.scan(1'h0, 32'h0000_0000, 8, s);
    // Realign to the system clock before touching its inputs
    tick(1);
  endtask

  task automatic t_ir_and_status();
    logic [31:0] d;
    st.scan(1'h1, 32'h0000_0003, 4, d);
    chk_word(d, 32'h0000_0001);
    rd_status(d);
    chk_word(d, 32'h0000_0001);
    core_quiesce = 1'h1;
    tick(2);
    chk_bit(quiesce_request_n, 1'h0);
    rd_status(d);
    chk_word(d, 32'h0000_0009);
    core_quiesce = 1'h0;
    checkstop_sel = 1'h1;
    core_checkstop = 1'h1;
    tick(2);
    chk_bit(alt_pin_out, 1'h0);
    chk_bit(alt_pin_oe, 1'h1);
    rd_status(d);
    chk_word(d, 32'h0000_0011);
    core_checkstop = 1'h0;
    checkstop_sel = 1'h0;
    alt_pin_function_oe = 1'h1;
    alt_pin_function_out = 1'h1;
    tick(2);
    chk_bit(alt_pin_out, 1'h1);
    chk_bit(alt_pin_oe, 1'h1);
    alt_pin_pad = 1'h0;
    tick(6);
    chk_bit(alt_pin_in, 1'h0);
  endtask

  // One reset sequence, started from outside or by the core
  task automatic t_line(input logic hard, input logic ext);
    int w;
    int c;
    if (ext) fork st.pull(hard); join_none
    else begin
      if (hard) core_hard_req = 1'h1;
      else core_soft_req = 1'h1;
      tick(1);
      core_hard_req = 1'h0;
      core_soft_req = 1'h0;
    end
    for (w = 0; w < 20 && (hard ? hard_reset_n_oe : soft_reset_n_oe) !== 1'h1;
         w++) tick(1);
    if (hard) chk_bit(core_hard_reset, 1'h1);
    else if (ext) chk_bit(core_soft_exception, 1'h1);
    c = 0;
    while ((hard ? hard_reset_n_oe : soft_reset_n_oe) === 1'h1 &&
           c < 600) begin
      c++;
      tick(1);
    end
    chk_word(c, RESET_PULSE_CYCLES);
    tick(2);
    chk_bit(hard ? hard_reset_n_in : soft_reset_n_in, 1'h1);
  endtask

  // Fill past full with the reader stalled, then drain
  task automatic t_fifo();
    logic [31:0] d;
    int i;
    int w;
    st.scan(1'h1, {28'h000_0000, OP_DATA_WR}, 4, d);
    // Each capture reads back the word handed over by the scan before
    for (i = 0; i < 34; i++) begin
      st.scan(1'h0, 32'h1000_0000 + i, 32, d);
      if (i > 0) chk_word(d, 32'h1000_0000 + i - 1);
    end
    rd_status(d);
    chk_word(d, 32'h0000_00E1);
    debug_ready = 1'h1;
    for (i = 0; i < 33; i++) begin
      for (w = 0; w < 10 && debug_valid !== 1'h1; w++) tick(1);
      chk_word(debug_data, 32'h1000_0000 + i);
      tick(1);
    end
    tick(10);
    chk_bit(debug_valid, 1'h0);
    rd_status(d);
    chk_word(d, 32'h0000_0081);
  endtask

  task automatic t_tap_resets();
    logic [31:0] d;
    logic o;
    st.detach();
    chk_bit(tdo_oe, 1'h0);
    st.attach();
    rd_status(d);
    chk_word(d, 32'h0000_0001);
    st.scan(1'h1, 32'h0000_0003, 4, d);
    st.drive(1'h0, 1'h0);
    repeat (6) st.step(1'h0, 1'h0, o);
    st.drive(1'h1, 1'h0);
    st.step(1'h0, 1'h0, o);
    st.scan(1'h0, 32'h0000_00A5, 8, d);
    chk_word(d, 32'h0000_00FE);
    st.drive(1'h1, 1'h1);
  endtask

  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  initial begin
    rst_n = 1'h0;
    core_quiesce = 1'h0;
    core_checkstop = 1'h0;
    core_soft_req = 1'h0;
    core_hard_req = 1'h0;
    checkstop_sel = 1'h0;
    alt_pin_function_out = 1'h0;
    alt_pin_function_oe = 1'h0;
    alt_pin_pad = 1'h1;
    debug_ready = 1'h0;
    tick(12);
    rst_n = 1'h1;
    tick(2);
    st.attach();
    t_ir_and_status();
    t_line(1'h0, 1'h1);
    t_line(1'h0, 1'h0);
    t_line(1'h1, 1'h1);
    t_line(1'h1, 1'h0);
    t_fifo();
    t_tap_resets();
    print_verdict();
  end
endmodule
`default_nettype wire

/* cop_port_chk.sv */
// Concurrent checks on the debug observation port pins
`timescale 1ns/10ps
`default_nettype none
module cop_port_chk
  import cop_port_pkg::*;
(
  // System clock, reset and test clock
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  // Test link
  input wire logic tdo,
  input wire logic tdo_oe,
  // Quiesce and core side
  input wire logic quiesce_request_n,
  input wire logic core_quiesce,
  input wire logic core_checkstop,
  input wire logic core_soft_exception,
  // Reset lines
  input wire logic soft_reset_n_in,
  input wire logic soft_reset_n_oe,
  input wire logic hard_reset_n_in,
  input wire logic hard_reset_n_oe,
  // Multiplexed pin
  input wire logic checkstop_sel,
  input wire logic alt_pin_function_out,
  input wire logic alt_pin_function_oe,
  input wire logic alt_pin_out,
  input wire logic alt_pin_oe
);
  logic [10:0] soft_cnt_q;
  logic [10:0] hard_cnt_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Pulse lengths exceed any repetition count, so count them here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) soft_cnt_q <= '0;
    else soft_cnt_q <= soft_reset_n_oe ? soft_cnt_q + 11'h001 : '0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hard_cnt_q <= '0;
    else hard_cnt_q <= hard_reset_n_oe ? hard_cnt_q + 11'h001 : '0;
  end

  a_tdo_fall_edge: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  a_tdo_oe_fall: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo_oe moved while tck high");
  a_quiesce_low: assert property (core_quiesce |=> !quiesce_request_n)
    else $error("quiesce request not low");
  a_quiesce_high: assert property (!core_quiesce |=> quiesce_request_n)
    else $error("quiesce request low without cause");
  a_soft_pulse_len: assert property ($fell(soft_reset_n_oe) |->
    soft_cnt_q == RESET_PULSE_CYCLES) else $error("soft pulse length");
  a_hard_pulse_len: assert property ($fell(hard_reset_n_oe) |->
    hard_cnt_q == RESET_PULSE_CYCLES) else $error("hard pulse length");
  a_soft_ext_start: assert property ($fell(soft_reset_n_in) &&
    !soft_reset_n_oe |-> ##[1:6] soft_reset_n_oe)
    else $error("external soft reset not taken");
  a_hard_ext_start: assert property ($fell(hard_reset_n_in) &&
    !hard_reset_n_oe |-> ##[1:6] hard_reset_n_oe)
    else $error("external hard reset not taken");
  a_exception_pulse: assert property (core_soft_exception |=>
    !core_soft_exception) else $error("exception longer than a cycle");
  a_checkstop_pin: assert property (checkstop_sel |=> alt_pin_oe &&
    alt_pin_out == !$past(core_checkstop)) else $error("check-stop pin");
  a_alt_pass: assert property (!checkstop_sel |=>
    alt_pin_out == $past(alt_pin_function_out) &&
    alt_pin_oe == $past(alt_pin_function_oe)) else $error("alt pin drive");
endmodule

bind cop_port cop_port_chk cop_port_chk_inst (
  .clk(clk), .rst_n(rst_n), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
  .quiesce_request_n(quiesce_request_n), .core_quiesce(core_quiesce),
  .core_checkstop(core_checkstop),
  .core_soft_exception(core_soft_exception),
  .soft_reset_n_in(soft_reset_n_in), .soft_reset_n_oe(soft_reset_n_oe),
  .hard_reset_n_in(hard_reset_n_in), .hard_reset_n_oe(hard_reset_n_oe),
  .checkstop_sel(checkstop_sel),
  .alt_pin_function_out(alt_pin_function_out),
  .alt_pin_function_oe(alt_pin_function_oe),
  .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe)
);
`default_nettype wire

/* cop_port_pkg.sv */
// Constants and types shared by the debug observation port files
package cop_port_pkg;

  localparam int IR_WIDTH = 4;
  localparam int DATA_WIDTH = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int STATUS_WIDTH = 8;

  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_WIDTH-1:0] IR_RESET = 4'hF;
  localparam logic [IR_WIDTH-1:0] OP_BYPASS = 4'hF;
  localparam logic [IR_WIDTH-1:0] OP_DATA_WR = 4'h2;
  localparam logic [IR_WIDTH-1:0] OP_STATUS_RD = 4'h3;

  // Status word bit positions
  localparam int ST_ONE = 0;
  localparam int ST_SOFT_SEQ = 1;
  localparam int ST_HARD_SEQ = 2;
  localparam int ST_QUIESCE = 3;
  localparam int ST_CHECKSTOP = 4;
  localparam int ST_FIFO_FULL = 5;
  localparam int ST_PENDING = 6;
  localparam int ST_OVERFLOW = 7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_PULSE_CYCLES = 512;
  localparam int PULSE_CNT_WIDTH = 10;
  localparam logic [PULSE_CNT_WIDTH-1:0] PULSE_LAST =
    10'h1FF;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
    UPDATE_IR
  } tap_state_t;

endpackage

/* debug_station.sv */
// Debug station model driving the test link and the reset lines
`timescale 1ns/10ps
`default_nettype none
module debug_station (
  // Test link
  output logic tck,
  output logic trst_n,
  output logic trst_driven,
  output logic tms,
  output logic tms_driven,
  output logic tdi,
  output logic tdi_driven,
  input wire logic tdo,
  // Open-drain reset pulls
  output logic soft_pull,
  output logic hard_pull
);
  // Unplugged at start: tck still, board pull-down on test reset
  initial begin
    tck = 1'h0;
    trst_n = 1'h0;
    trst_driven = 1'h0;
    tms = 1'h1;
    tms_driven = 1'h0;
    tdi = 1'h1;
    tdi_driven = 1'h0;
    soft_pull = 1'h0;
    hard_pull = 1'h0;
  end

  // Released lines toggle so a stale value never looks valid
  task automatic step(input logic m, input logic d, output logic o);
    tms = tms_driven ? m : !tms;
    tdi = tdi_driven ? d : !tdi;
    #40;
    o = tdo;
    tck = 1'h1;
    #40;
    tck = 1'h0;
  endtask

  task automatic attach();
    logic o;
    trst_driven = 1'h1;
    trst_n = 1'h1;
    tms_driven = 1'h1;
    tdi_driven = 1'h1;
    repeat (5) step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
  endtask

  task automatic detach();
    trst_driven = 1'h0;
    trst_n = 1'h0;
    #40;
  endtask

  task automatic drive(input logic m_en, input logic d_en);
    tms_driven = m_en;
    tdi_driven = d_en;
  endtask

  // From Run-Idle back to Run-Idle, shifting n bits LSB first
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic o;
    int i;
    dout = '0;
    step(1'h1, 1'h0, o);
    if (ir) step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
    step(1'h0, 1'h0, o);
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
  endtask

  // Pull low, then release; the line is never driven high
  task automatic pull(input logic hard);
    if (hard) hard_pull = 1'h1;
    else soft_pull = 1'h1;
    #200;
    hard_pull = 1'h0;
    soft_pull = 1'h0;
  endtask
endmodule
`default_nettype wire

/* stream_if.sv */
// Valid/ready word stream between the port logic and its FIFO
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* word_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Streams
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("word_fifo: DEPTH must be a power of two, 2 or more");
    end
    if (WIDTH < 1) begin
      $error("word_fifo: WIDTH must be positive");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rd_ptr_q[AW-1:0]];
  assign push = wr.valid && !full;
  assign pop = rd.ready && !empty;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule
`default_nettype wire
